// >>> logic/load_ctrl_pkg.sv
// Shared constants and types for the load input control block
package load_ctrl_pkg;

    // ------------------------------------------------------------
    // Bus geometry and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] CMD_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] STAT_OFFSET = 4'h8;

    // ------------------------------------------------------------
    // Configuration word, bit 0 is sb_onoff
    // ------------------------------------------------------------
    typedef struct packed {
        logic reg_fast;         // Voltage regulator speed, 1 = fast
        logic leave_auto;       // Keep input state on leaving remote
        logic pf_auto;          // Switch on again after power fail
        logic powerup_restore;  // Power-up mode, 1 = restore
        logic status_dc;        // Status pin shows input on, not CV
        logic [2:0] pin2_en;    // {overpower, overcurrent, overvoltage}
        logic [1:0] pin1_en;    // {power fail, overtemperature}
        logic sb_invert;        // Standby input polarity inverted
        logic sb_onoff;         // Standby input may also switch on
    } cfg_t;

    localparam int CFG_W = 12;
    localparam int CFG_LANE0_W = 8;
    localparam int CFG_LANE1_W = CFG_W - CFG_LANE0_W;
    localparam cfg_t CFG_RESET = 12'h01c;

    // Command register bits, write-only strobes
    localparam int CMD_ON_BIT = 0;
    localparam int CMD_OFF_BIT = 1;

    // Status register bit positions
    localparam int STAT_ON_BIT = 0;
    localparam int STAT_REMOTE_BIT = 1;
    localparam int STAT_SB_BIT = 2;
    localparam int STAT_ARMED_BIT = 3;
    localparam int STAT_PFHOLD_BIT = 4;
    localparam int STAT_PINS_LSB = 8;

    // ------------------------------------------------------------
    // Alarm sources and analog interface output pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic constant_voltage_regulation;
        logic overpower_alarm;
        logic overcurrent_alarm;
        logic overvoltage_alarm;
        logic power_fail_alarm;
        logic overtemperature_alarm;
    } alarm_t;

    typedef struct packed {
        logic status_pin;
        logic alarm2_pin;
        logic alarm1_pin;
    } pins_t;

    localparam int PINS_W = 3;

endpackage

// >>> logic/alarm_pin_router.sv
// Routes alarm sources and input status onto the analog interface pins
`timescale 1ns/1ps
module alarm_pin_router (
    input wire logic clk_i,
    input wire logic rst_i,
    input load_ctrl_pkg::cfg_t cfg_i,
    input load_ctrl_pkg::alarm_t alarm_i,
    input wire logic input_on_i,
    output load_ctrl_pkg::pins_t pins_o
);
    import load_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Pin selection
    // ------------------------------------------------------------
    wire [1:0] pin1_src = {alarm_i.power_fail_alarm, alarm_i.overtemperature_alarm};
    wire [2:0] pin2_src = {alarm_i.overpower_alarm, alarm_i.overcurrent_alarm,
                           alarm_i.overvoltage_alarm};
    wire [2:0] pin2_hit;
    wire status_next;
    pins_t pins_next;

    // Each enabled source gates onto pin 2 separately
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_pin2
            assign pin2_hit[g] = pin2_src[g] & cfg_i.pin2_en[g]; // [RL4]
        end
    endgenerate

    assign status_next = cfg_i.status_dc ? input_on_i
                                         : alarm_i.constant_voltage_regulation; // [RL5]
    assign pins_next.alarm1_pin = |(pin1_src & cfg_i.pin1_en); // [RL3] [RL15]
    assign pins_next.alarm2_pin = |pin2_hit; // [RL15]
    assign pins_next.status_pin = status_next;

    // Pins are registered so the pins never glitch on source skew
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o <= '0;
        end else begin
            pins_o <= pins_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_pin1_alarm_or: assert property ( // [RL3]
        ##1 pins_o.alarm1_pin == |($past(pin1_src) & $past(cfg_i.pin1_en)))
        else $error("alarm pin 1 does not follow its enabled sources");
    chk_pin2_alarm_or: assert property ( // [RL4]
        ##1 pins_o.alarm2_pin == |($past(pin2_src) & $past(cfg_i.pin2_en)))
        else $error("alarm pin 2 does not follow its enabled sources");
    chk_status_pin_sel: assert property ( // [RL5]
        !cfg_i.status_dc && alarm_i.constant_voltage_regulation |=> pins_o.status_pin)
        else $error("status pin misses constant voltage mode");
    chk_masked_alarm_quiet: assert property ( // [RL15]
        cfg_i.pin2_en == 3'h1 && !alarm_i.overvoltage_alarm |=> !pins_o.alarm2_pin)
        else $error("alarm pin 2 shows a disabled source");
endmodule

// >>> logic/load_input_ctrl.sv
// Load input switching control with standby, power fail and remote handling
`timescale 1ns/1ps

// What this block does
// [RL1] Off-only standby action: standby input changes only ever switch the input off.
// [RL2] On/off action: standby switches off and back on, if another location armed it.
// [RL3] Alarm pin 1 defaults to overtemperature plus power fail; three allowed mixes.
// [RL4] Alarm pin 2 defaults to overvoltage; seven mixes of voltage, current, power.
// [RL5] Status pin shows constant voltage mode, or optionally the input on state.
// [RL6] Power-up mode off: input is always off after power-on.
// [RL7] Power-up mode restore: input returns to its state before last switch-off.
// [RL8] Power-fail reaction off: alarm switches input off until a user turns it on.
// [RL9] Power-fail reaction auto: input returns on when cause clears, if it was on.
// [RL10] Leave-remote off: input switches off when control goes from remote to manual.
// [RL11] Leave-remote auto: input keeps its state when control goes back to manual.
// [RL12] A setting selects slow or fast voltage regulator speed.
// [RL13] Standby input polarity setting swaps levels and their meaning.
// [RL14] Power-up mode resets to off.
// [RL15] Each alarm pin is the OR of its enabled active alarm sources.
module load_input_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [load_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [load_ctrl_pkg::DATA_W-1:0] wb_dat_i,
    output logic [load_ctrl_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog interface and internal sources
    input wire logic remote_standby_input_i,
    input wire logic remote_active_i,
    input load_ctrl_pkg::alarm_t alarm_i,
    input wire logic stored_restore_i,
    input wire logic stored_on_i,
    output load_ctrl_pkg::pins_t pins_o,
    output logic input_on_o,
    output logic powerup_restore_o,
    output logic regulator_fast_o
);
    import load_ctrl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cfg_t cfg_reg;
    cfg_t cfg_next;
    logic input_on_reg;
    logic input_on_next;
    logic boot_reg;
    logic sb_prev_reg;
    logic pf_prev_reg;
    logic remote_prev_reg;
    logic armed_reg;
    logic armed_next;
    logic pf_hold_reg;
    logic pf_hold_next;
    logic ack_reg;
    logic [DATA_W-1:0] rdata_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr_req = bus_req & wb_we_i;
    wire cfg_hit = (wb_adr_i == CFG_OFFSET);
    wire cmd_hit = (wb_adr_i == CMD_OFFSET);
    wire stat_hit = (wb_adr_i == STAT_OFFSET);
    wire cfg_wr = wr_req & cfg_hit;
    wire cmd_wr = wr_req & cmd_hit & wb_sel_i[0];
    wire cmd_on = cmd_wr & wb_dat_i[CMD_ON_BIT];
    wire cmd_off = cmd_wr & wb_dat_i[CMD_OFF_BIT];

    // Byte-lane merge of the configuration word
    wire [CFG_W-1:0] cfg_mask = {{CFG_LANE1_W{wb_sel_i[1]}}, {CFG_LANE0_W{wb_sel_i[0]}}};
    wire [CFG_W-1:0] cfg_merged = (cfg_reg & ~cfg_mask) | (wb_dat_i[CFG_W-1:0] & cfg_mask);
    cfg_t cfg_cand;
    assign cfg_cand = cfg_t'(cfg_merged);

    // An empty alarm selection is not a legal mix, keep the old field then
    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_wr) begin
            cfg_next = cfg_cand;
            if (cfg_cand.pin1_en == 2'h0) begin
                cfg_next.pin1_en = cfg_reg.pin1_en; // [RL3]
            end
            if (cfg_cand.pin2_en == 3'h0) begin
                cfg_next.pin2_en = cfg_reg.pin2_en; // [RL4]
            end
        end
    end

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Polarity is applied before the edge so both levels and meaning swap
    wire sb_active = remote_standby_input_i ^ cfg_reg.sb_invert; // [RL13]
    wire sb_rise = ~boot_reg & sb_active & ~sb_prev_reg;
    wire sb_fall = ~boot_reg & ~sb_active & sb_prev_reg;
    wire pf_now = alarm_i.power_fail_alarm;
    wire pf_rise = ~boot_reg & pf_now & ~pf_prev_reg;
    wire pf_fall = ~boot_reg & ~pf_now & pf_prev_reg;
    wire leave_remote = ~boot_reg & ~remote_active_i & remote_prev_reg;

    // Switch-off causes
    wire sb_off = sb_rise; // [RL1] [RL2]
    wire leave_off = leave_remote & ~cfg_reg.leave_auto; // [RL10] [RL11]
    wire any_off = sb_off | pf_rise | leave_off | cmd_off; // [RL8]

    // Switch-on causes; a user on is refused while standby or the power fail alarm is active
    wire user_on = cmd_on & ~sb_active & ~pf_now;
    wire sb_on = sb_fall & cfg_reg.sb_onoff & armed_reg & ~pf_now; // [RL1] [RL2]
    wire pf_on = pf_fall & cfg_reg.pf_auto & pf_hold_reg & ~sb_active; // [RL9]
    // A command taken in the boot cycle races the restore; an off still wins
    wire boot_on = boot_reg & stored_restore_i & stored_on_i; // [RL6] [RL7]
    wire any_on = user_on | sb_on | pf_on | boot_on;

    // Off wins over on so a fault in the same cycle always removes the load
    assign input_on_next = any_off ? 1'b0 : (any_on ? 1'b1 : input_on_reg);

    // Arming remembers that another control location switched the input on
    always_comb begin
        armed_next = armed_reg;
        if (cmd_off | leave_off) begin
            armed_next = 1'b0;
        end
        if (user_on | boot_on) begin
            armed_next = 1'b1; // [RL2]
        end
    end

    // Power fail remembers whether the input was on when the alarm came
    always_comb begin
        pf_hold_next = pf_hold_reg;
        if (pf_rise) begin
            pf_hold_next = input_on_reg; // [RL9]
        end else if (pf_fall | user_on | cmd_off) begin
            pf_hold_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset is the power-on; the boot cycle samples levels without events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= CFG_RESET; // [RL14]
            input_on_reg <= 1'b0; // [RL6]
            boot_reg <= 1'b1;
            sb_prev_reg <= 1'b0;
            pf_prev_reg <= 1'b0;
            remote_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            pf_hold_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            input_on_reg <= input_on_next;
            boot_reg <= 1'b0;
            sb_prev_reg <= sb_active;
            pf_prev_reg <= pf_now;
            remote_prev_reg <= remote_active_i;
            armed_reg <= armed_next;
            pf_hold_reg <= pf_hold_next;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        stat_word = '0;
        stat_word[STAT_ON_BIT] = input_on_reg;
        stat_word[STAT_REMOTE_BIT] = remote_active_i;
        stat_word[STAT_SB_BIT] = sb_active;
        stat_word[STAT_ARMED_BIT] = armed_reg;
        stat_word[STAT_PFHOLD_BIT] = pf_hold_reg;
        stat_word[STAT_PINS_LSB +: PINS_W] = pins_o;
    end

    // Unmapped and command reads return zero
    assign rdata_next = cfg_hit ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg}
                      : (stat_hit ? stat_word : '0);

    // One wait state: answer in the cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            rdata_reg <= bus_req ? rdata_next : rdata_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign input_on_o = input_on_reg;
    assign powerup_restore_o = cfg_reg.powerup_restore;
    assign regulator_fast_o = cfg_reg.reg_fast; // [RL12]

    alarm_pin_router u_router (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg_reg),
        .alarm_i(alarm_i),
        .input_on_i(input_on_reg),
        .pins_o(pins_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_offonly_never_on: assert property ( // [RL1]
        !cfg_reg.sb_onoff && sb_fall && !cmd_on && !pf_fall |=> !input_on_reg)
        else $error("off-only standby switched the input on");
    chk_standby_rearm_on: assert property ( // [RL2]
        cfg_reg.sb_onoff && armed_reg && sb_fall && !pf_now && !any_off
        |=> input_on_reg)
        else $error("armed standby release did not switch on");
    chk_unarmed_stays_off: assert property ( // [RL2]
        sb_fall && !armed_reg && !input_on_reg && !cmd_on && !pf_on |=> !input_on_reg)
        else $error("unarmed standby release switched on");
    chk_standby_off: assert property ( // [RL13]
        $rose(sb_active) && !boot_reg |-> ##1 !input_on_reg)
        else $error("standby did not switch the input off");
    chk_powerup_off: assert property ( // [RL6]
        boot_reg && !stored_restore_i |=> !input_on_reg)
        else $error("input on after power-up in off mode");
    chk_powerup_restore: assert property ( // [RL7]
        boot_reg && stored_restore_i |=> input_on_reg == $past(stored_on_i))
        else $error("power-up restore lost the stored state");
    chk_pf_stays_off: assert property ( // [RL8]
        pf_rise ##1 (!cmd_on && !pf_on && !sb_on)[*3] |-> !input_on_reg)
        else $error("input came back on during power fail hold");
    chk_pf_auto_on: assert property ( // [RL9]
        cfg_reg.pf_auto && pf_fall && pf_hold_reg && !sb_active && !any_off
        |=> input_on_reg)
        else $error("power fail auto did not restore the input");
    chk_leave_remote_off: assert property ( // [RL10]
        leave_remote && !cfg_reg.leave_auto |=> !input_on_reg)
        else $error("input stayed on after leaving remote");
    chk_leave_remote_keep: assert property ( // [RL11]
        leave_remote && cfg_reg.leave_auto && !any_off && !any_on
        |=> input_on_reg == $past(input_on_reg))
        else $error("input changed on leaving remote in auto mode");
    chk_reg_speed_out: assert property ( // [RL12]
        cfg_wr && wb_sel_i[1] |=> regulator_fast_o == $past(wb_dat_i[CFG_W-1]))
        else $error("regulator speed did not follow its setting");
    chk_bus_ack_once: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");

    // Configuration guards; an empty selection would silence a pin for good
    chk_pin1_never_empty: assert property ( // [RL3]
        cfg_reg.pin1_en != 2'h0)
        else $error("alarm pin 1 has no source enabled");
    chk_pin2_never_empty: assert property ( // [RL4]
        cfg_reg.pin2_en != 3'h0)
        else $error("alarm pin 2 has no source enabled");
    chk_cfg_write_takes: assert property (
        cfg_wr && wb_sel_i[1:0] == 2'h3 && cfg_cand.pin1_en != 2'h0 && cfg_cand.pin2_en != 3'h0
        |=> cfg_reg == $past(wb_dat_i[CFG_W-1:0]))
        else $error("configuration write did not take");

    // Read answers, taken from the state at the request edge
    chk_cfg_read_data: assert property (
        bus_req && !wb_we_i && cfg_hit
        |=> wb_dat_o == {{(DATA_W-CFG_W){1'b0}}, $past(cfg_reg)})
        else $error("configuration read returned a wrong word");
    chk_status_read_on: assert property (
        bus_req && !wb_we_i && stat_hit |=> wb_dat_o[STAT_ON_BIT] == $past(input_on_reg))
        else $error("status read shows a wrong input state");
    chk_unmapped_read_zero: assert property (
        bus_req && !wb_we_i && !cfg_hit && !stat_hit |=> wb_dat_o == '0)
        else $error("unmapped read returned nonzero data");

    // Switch-off paths must take effect in the very next cycle
    chk_cmd_off_now: assert property (
        cmd_off |=> !input_on_reg)
        else $error("off command did not switch the input off");
    chk_pf_off_now: assert property ( // [RL8]
        pf_rise |=> !input_on_reg)
        else $error("power fail did not switch the input off");
    chk_user_on_refused: assert property ( // [RL8]
        cmd_on && (sb_active || pf_now) && !boot_reg && !input_on_reg |=> !input_on_reg)
        else $error("on command taken during standby or power fail");
    chk_pf_hold_capture: assert property ( // [RL9]
        pf_rise |=> pf_hold_reg == $past(input_on_reg))
        else $error("power fail hold lost the input state");
    chk_armed_clear: assert property ( // [RL2]
        (cmd_off || leave_off) && !user_on && !boot_on |=> !armed_reg)
        else $error("arming survived a switch-off");
endmodule

// >>> bench/ext_ctrl_model.sv
// Model of the external controller that drives standby and reads the analog pins
`timescale 1ns/1ps
module ext_ctrl_model (
    input wire logic clk_i,
    input wire logic sb_active_i,
    input wire logic invert_i,
    input load_ctrl_pkg::pins_t pins_i,
    output logic remote_standby_input_o,
    output load_ctrl_pkg::pins_t pins_seen_o
);
    import load_ctrl_pkg::*;
    // The wanted action goes out through the polarity the device is set to
    initial begin
        remote_standby_input_o = 1'b0;
        pins_seen_o = '0;
    end
    // Pins are read one cycle late, as a slow controller would see them
    always @(posedge clk_i) begin
        remote_standby_input_o <= sb_active_i ^ invert_i;
        pins_seen_o <= pins_i;
    end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the load input control block
`timescale 1ns/1ps
module tb_top;
    import load_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wd = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sb_act = 1'b0;
    logic sb_inv = 1'b0;
    logic sb_pin;
    logic remote = 1'b0;
    logic st_restore = 1'b0;
    logic st_on = 1'b0;
    alarm_t al = '0;
    pins_t pins_o;
    pins_t pins_seen;
    logic input_on_o;
    logic powerup_restore_o;
    logic regulator_fast_o;
    logic [31:0] rdata;
    int failures = 0;
    int samples_checked = 0;

    load_input_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .remote_standby_input_i(sb_pin),
        .remote_active_i(remote), .alarm_i(al), .stored_restore_i(st_restore),
        .stored_on_i(st_on), .pins_o(pins_o), .input_on_o(input_on_o),
        .powerup_restore_o(powerup_restore_o), .regulator_fast_o(regulator_fast_o));
    ext_ctrl_model ctrl_u (.clk_i(clk_i), .sb_active_i(sb_act), .invert_i(sb_inv),
        .pins_i(pins_o), .remote_standby_input_o(sb_pin), .pins_seen_o(pins_seen));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial forever #50 clk_i = ~clk_i;
    // Whole plan needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        print_verdict();
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    // One classic cycle; held until ack is sampled, no latency assumed
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= lanes;
        wb_adr <= adr;
        wb_wd <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rdata = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
        settle();
    endtask
    task automatic set_al(input logic [5:0] v);
        @(posedge clk_i);
        al <= alarm_t'(v);
        settle();
    endtask
    task automatic set_sb(input logic v);
        @(posedge clk_i);
        sb_act <= v;
        settle();
    endtask
    task automatic set_rem(input logic v);
        @(posedge clk_i);
        remote <= v;
        settle();
    endtask
    task automatic do_reset(input logic r, input logic o);
        @(posedge clk_i);
        rst_i <= 1'b1;
        st_restore <= r;
        st_on <= o;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
    endtask
    task automatic chk_on(input logic e);
        chk(32'(input_on_o), 32'(e));
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b0, 1'b1);
        chk_on(1'b0);
        wb_cycle(1'b0, CFG_OFFSET, 32'h0);
        chk(rdata, 32'h01c);
        // Empty pin selections are refused and keep the old fields
        wb_cycle(1'b1, CFG_OFFSET, 32'h0);
        wb_cycle(1'b0, CFG_OFFSET, 32'h0);
        chk(rdata, 32'h01c);
        wb_cycle(1'b0, 4'hc, 32'h0);
        chk(rdata, 32'h0);
        chk(32'(regulator_fast_o), 32'h0);
        wb_cycle(1'b1, CFG_OFFSET, 32'h81c);
        chk(32'(regulator_fast_o), 32'h1);
        // A lane 0 write leaves the speed bit in lane 1 alone
        lanes = 4'h1;
        wb_cycle(1'b1, CFG_OFFSET, 32'h01c);
        lanes = 4'hf;
        chk(32'(regulator_fast_o), 32'h1);
        // Default pin assignment, then every legal alarm mix
        set_al(6'h02);
        chk(32'(pins_seen), 32'h1);
        set_al(6'h18);
        chk(32'(pins_seen), 32'h0);
        set_al(6'h24);
        chk(32'(pins_seen), 32'h6);
        for (int m = 1; m < 4; m++) begin
            wb_cycle(1'b1, CFG_OFFSET, 32'h010 | (m << 2));
            for (int j = 0; j < 2; j++) begin
                set_al(6'h1 << j);
                chk(32'(pins_seen.alarm1_pin), 32'(m[j]));
            end
        end
        for (int m = 1; m < 8; m++) begin
            wb_cycle(1'b1, CFG_OFFSET, 32'h004 | (m << 4));
            for (int j = 0; j < 3; j++) begin
                set_al(6'h4 << j);
                chk(32'(pins_seen.alarm2_pin), 32'(m[j]));
            end
        end
        set_al(6'h20);
        wb_cycle(1'b1, CFG_OFFSET, 32'h09c);
        chk(32'(pins_seen.status_pin), 32'h0);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        chk(32'(pins_seen.status_pin), 32'h1);
        // Standby off-only, then on/off with arming
        wb_cycle(1'b1, CFG_OFFSET, 32'h01c);
        set_sb(1'b1);
        chk_on(1'b0);
        set_sb(1'b0);
        chk_on(1'b0);
        wb_cycle(1'b1, CFG_OFFSET, 32'h01d);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        set_sb(1'b1);
        chk_on(1'b0);
        set_sb(1'b0);
        chk_on(1'b1);
        wb_cycle(1'b1, CMD_OFFSET, 32'h2);
        set_sb(1'b1);
        set_sb(1'b0);
        chk_on(1'b0);
        // Inverted polarity: a low pin now means standby
        wb_cycle(1'b1, CFG_OFFSET, 32'h01f);
        @(posedge clk_i);
        sb_inv <= 1'b1;
        settle();
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        chk_on(1'b1);
        set_sb(1'b1);
        chk_on(1'b0);
        set_sb(1'b0);
        chk_on(1'b1);
        wb_cycle(1'b1, CFG_OFFSET, 32'h01c);
        @(posedge clk_i);
        sb_inv <= 1'b0;
        settle();
        // Power fail reaction off, then auto; an on command is refused meanwhile
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        set_al(6'h02);
        chk_on(1'b0);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        chk_on(1'b0);
        set_al(6'h00);
        chk_on(1'b0);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        chk_on(1'b1);
        wb_cycle(1'b1, CFG_OFFSET, 32'h21c);
        set_al(6'h02);
        chk_on(1'b0);
        set_al(6'h00);
        chk_on(1'b1);
        wb_cycle(1'b1, CMD_OFFSET, 32'h2);
        set_al(6'h02);
        set_al(6'h00);
        chk_on(1'b0);
        // Leaving remote control, off then keep
        set_rem(1'b1);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        set_rem(1'b0);
        chk_on(1'b0);
        wb_cycle(1'b1, CFG_OFFSET, 32'h41c);
        set_rem(1'b1);
        wb_cycle(1'b1, CMD_OFFSET, 32'h1);
        set_rem(1'b0);
        chk_on(1'b1);
        // Status word: input on and armed, no standby, hold or pins
        wb_cycle(1'b0, STAT_OFFSET, 32'h0);
        chk(rdata, 32'h009);
        // Power-up mode mirror, then restore of the stored state
        wb_cycle(1'b1, CFG_OFFSET, 32'h51c);
        chk(32'(powerup_restore_o), 32'h1);
        do_reset(1'b1, 1'b1);
        chk_on(1'b1);
        chk(32'(powerup_restore_o), 32'h0);
        do_reset(1'b1, 1'b0);
        chk_on(1'b0);
        print_verdict();
    end
endmodule
